// ---- rtl/tt3_pkg.sv ----
// constants, register map and state record of the third timer/counter unit
// Functional notes
// - mode comes from run, uart clock selects, capture select, clock-out enable; run 0 is off
// - counter advances only while run control reads 1
// - overflow sets bit 7 unless uart clock select or clock-out; software clears
// - trigger falling edge sets bit 6 in capture, reload, baud modes; software clears
// - both flags request one interrupt gated by the unit interrupt enable
// - receive select bit 5 routes overflow pulses to uart receive clock
// - transmit select bit 4 routes overflow pulses to uart transmit clock
// - trigger enable bit 3 allows capture or reload; clear means trigger ignored
// - source 0 counts machine ticks (clock/6), every clock in baud and clock-out; 1 counts count pin falling edges
// - capture select bit 0 picks capture or reload; ignored when uart clocked
// - clock-out enable bit 1 acts only in clock-out mode
// - down-count enable resets 0; when set in auto-reload mode trigger level picks direction
// - capture mode without trigger enable is a plain 16-bit counter with flag
// - capture edge copies counter low/high bytes into capture low/high
// - capture mode never reloads; counter keeps running after a capture
// - auto-reload loads capture registers on overflow or enabled trigger edge
// - down count underflows at capture value, sets flag, loads all ones; external flag toggles
// - trigger edge needs 1 then 0 in two machine cycles, flag set in third
// - baud mode trigger edge sets external flag without reload
package tt3_pkg;
	// register indices; byte address is four times the index
	localparam logic [9:0] CTRL_IDX = 10'h0C8;
	localparam logic [9:0] MODE_IDX = 10'h0C9;
	localparam logic [9:0] CAPL_IDX = 10'h0CA;
	localparam logic [9:0] CAPH_IDX = 10'h0CB;
	localparam logic [9:0] CNTL_IDX = 10'h0CC;
	localparam logic [9:0] CNTH_IDX = 10'h0CD;
	localparam logic [9:0] IEN_IDX = 10'h0CE;
	// control register bits
	localparam int TF_BIT = 7;
	localparam int EXF_BIT = 6;
	localparam int RCLK_BIT = 5;
	localparam int TX_CLOCK_SELECT_BIT = 4;
	localparam int EXEN_BIT = 3;
	localparam int TR_BIT = 2;
	localparam int CT_BIT = 1;
	localparam int CPRL_BIT = 0;
	// mode register bits
	localparam int OE_BIT = 1;
	localparam int DOWN_COUNT_ENABLE_BIT = 0;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] CAP_RST = 16'h0000;
	localparam logic IEN_RST = 1'b0;
	localparam logic [15:0] ALL_ONES = 16'hFFFF;
	// clocks per machine cycle, and the last prescaler state
	localparam int MACH_DIV = 6;
	localparam logic [2:0] MACH_LAST = 3'(MACH_DIV - 1);
	// uart clock pulses
	typedef struct packed {
		logic rx;
		logic tx;
	} tt3_baud_t;
	// whole state of the unit
	typedef struct packed {
		logic trig_s1;
		logic trig_s2;
		logic trig_prev;
		logic trig_cur;
		logic cpin_s1;
		logic cpin_s2;
		logic cpin_prev;
		logic cpin_cur;
		logic [2:0] presc;
		logic [7:0] ctrl;
		logic [1:0] mode;
		logic ien;
		logic [15:0] cnt;
		logic [15:0] cap;
		logic [7:0] rdata;
		logic clk_o;
		tt3_baud_t baud;
	} tt3_state_t;
endpackage

// ---- rtl/tt3_timer.sv ----
// third 16-bit timer/counter with capture, reload, clock-out and uart clock duty
`timescale 1ns/100ps
`default_nettype none
module tt3_timer
	import tt3_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// count pin, two-way
	input wire logic count_pin_i,
	output logic count_pin_o,
	output logic count_pin_oe_n,
	// trigger pin
	input wire logic trigger_input_i,
	// uart clock pulses and interrupt
	output tt3_baud_t baud_tick,
	output logic irq
);
	tt3_state_t q;
	tt3_state_t d;
	logic run;
	logic baud_m;
	logic clkout_m;
	logic cap_m;
	logic rld_m;
	logic updown_m;
	logic mtick;
	logic ev;
	logic down;
	logic hit;
	logic ovf;
	logic tedge;
	logic setup;
	logic acc;
	logic addr_ok;
	logic wr;
	logic [9:0] idx;
	logic [7:0] rd_val;

	// mode decode from the control and mode bits
	assign run = q.ctrl[TR_BIT];
	assign baud_m = q.ctrl[RCLK_BIT] | q.ctrl[TX_CLOCK_SELECT_BIT];
	assign clkout_m = !baud_m && !q.ctrl[CPRL_BIT] && q.mode[OE_BIT];
	assign cap_m = !baud_m && q.ctrl[CPRL_BIT];
	assign rld_m = !baud_m && !q.ctrl[CPRL_BIT] && !q.mode[OE_BIT];
	assign updown_m = rld_m && q.mode[DOWN_COUNT_ENABLE_BIT];

	// machine tick every sixth clock; baud and clock-out count every clock from the internal source
	assign mtick = (q.presc == MACH_LAST);
	always_comb
	begin
		if (!run)
			ev = 1'b0;
		else if (q.ctrl[CT_BIT])
			ev = mtick && q.cpin_prev && !q.cpin_cur;
		else
			ev = (baud_m || clkout_m) ? 1'b1 : mtick;
	end

	// direction follows the trigger level only with down count enabled
	assign down = updown_m && !q.trig_cur;
	assign hit = down ? (q.cnt == q.cap) : (q.cnt == ALL_ONES);
	assign ovf = ev && hit;

	// trigger edge: sampled 1 then 0 on two machine ticks, acted on at the next
	// in up/down mode the trigger is a direction level, so its edge does nothing
	assign tedge = run && q.ctrl[EXEN_BIT] && mtick && q.trig_prev && !q.trig_cur && !updown_m;

	// apb decode; zero wait states, read data latched in the setup cycle
	assign setup = psel && !penable;
	assign acc = psel && penable;
	assign idx = paddr[11:2];
	always_comb
	begin
		addr_ok = (paddr[1:0] == 2'h0);
		rd_val = 8'h00;
		if (idx == CTRL_IDX)
			rd_val = q.ctrl;
		else if (idx == MODE_IDX)
			rd_val = {6'h00, q.mode};
		else if (idx == CAPL_IDX)
			rd_val = q.cap[7:0];
		else if (idx == CAPH_IDX)
			rd_val = q.cap[15:8];
		else if (idx == CNTL_IDX)
			rd_val = q.cnt[7:0];
		else if (idx == CNTH_IDX)
			rd_val = q.cnt[15:8];
		else if (idx == IEN_IDX)
			rd_val = {7'h00, q.ien};
		else
			addr_ok = 1'b0;
	end
	assign wr = acc && pwrite && addr_ok && pstrb[0];
	assign pready = 1'b1;
	assign pslverr = acc && !addr_ok;
	assign prdata = {24'h000000, q.rdata};

	// next state of the whole unit
	always_comb
	begin
		d = q;
		// pin synchronisers
		d.trig_s1 = trigger_input_i;
		d.trig_s2 = q.trig_s1;
		d.cpin_s1 = count_pin_i;
		d.cpin_s2 = q.cpin_s1;
		d.presc = mtick ? 3'h0 : 3'(q.presc + 3'h1);
		// pins are looked at once per machine cycle
		if (mtick)
		begin
			d.trig_prev = q.trig_cur;
			d.trig_cur = q.trig_s2;
			d.cpin_prev = q.cpin_cur;
			d.cpin_cur = q.cpin_s2;
		end
		// software writes to configuration
		if (wr && idx == CTRL_IDX)
			d.ctrl = pwdata[7:0];
		if (wr && idx == MODE_IDX)
			d.mode = pwdata[1:0];
		if (wr && idx == IEN_IDX)
			d.ien = pwdata[0];
		// counting
		if (ev)
		begin
			if (down)
				d.cnt = hit ? ALL_ONES : 16'(q.cnt - 16'h0001);
			else if (!hit)
				d.cnt = 16'(q.cnt + 16'h0001);
			else if (cap_m)
				d.cnt = CNT_RST;
			else
				d.cnt = q.cap;
		end
		// trigger actions; baud and clock-out never load from the trigger
		if (tedge && rld_m)
			d.cnt = q.cap;
		if (tedge && cap_m)
			d.cap = q.cnt;
		// hardware sets win over a software clear in the same cycle
		if (ovf && !baud_m && !clkout_m)
			d.ctrl[TF_BIT] = 1'b1;
		if (tedge && (cap_m || rld_m || baud_m))
			d.ctrl[EXF_BIT] = 1'b1;
		if (ovf && updown_m)
			d.ctrl[EXF_BIT] = !q.ctrl[EXF_BIT];
		// clock-out toggles at each rollover
		if (ovf && clkout_m)
			d.clk_o = !q.clk_o;
		// overflow pulses to the uart clocks
		d.baud.rx = ovf && q.ctrl[RCLK_BIT];
		d.baud.tx = ovf && q.ctrl[TX_CLOCK_SELECT_BIT];
		// software data writes win: the user should stop the timer first
		if (wr && idx == CAPL_IDX)
			d.cap[7:0] = pwdata[7:0];
		if (wr && idx == CAPH_IDX)
			d.cap[15:8] = pwdata[7:0];
		if (wr && idx == CNTL_IDX)
			d.cnt[7:0] = pwdata[7:0];
		if (wr && idx == CNTH_IDX)
			d.cnt[15:8] = pwdata[7:0];
		if (setup)
			d.rdata = rd_val;
	end

	// one register bank for all state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q <= '0;
			q.ctrl <= CTRL_RST;
			q.mode <= MODE_RST;
			q.ien <= IEN_RST;
			q.cnt <= CNT_RST;
			q.cap <= CAP_RST;
		end
		else
			q <= d;
	end

	// outputs
	assign irq = q.ien && (q.ctrl[TF_BIT] || q.ctrl[EXF_BIT]);
	assign count_pin_o = q.clk_o;
	assign count_pin_oe_n = !clkout_m;
	assign baud_tick = q.baud;

	// counter holds while stopped
	run_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!run && !wr) |=> $stable(q.cnt))
		else $error("counter moved while stopped");

	// overflow raises flag outside uart and clock-out duty
	ovf_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ovf && !baud_m && !clkout_m) |=> q.ctrl[TF_BIT])
		else $error("overflow flag not set");

	// no overflow flag in baud duty
	baud_noflag_a: assert property (@(posedge pclk) disable iff (!presetn)
		(baud_m && !q.ctrl[TF_BIT] && !wr) |=> !q.ctrl[TF_BIT])
		else $error("overflow flag set in baud duty");

	// interrupt follows a raised flag
	irq_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		($rose(q.ctrl[TF_BIT]) && q.ien) |-> irq)
		else $error("interrupt missing after flag");

	// transmit pulse comes one clock after an overflow with select set
	tx_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		baud_tick.tx |-> ($past(ovf) && $past(q.ctrl[TX_CLOCK_SELECT_BIT])))
		else $error("stray transmit clock pulse");

	// enabled trigger edge sets the external flag
	ext_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		(tedge && (cap_m || rld_m || baud_m)) |=> q.ctrl[EXF_BIT])
		else $error("external flag not set");

	// capture copies the running count
	cap_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
		(tedge && cap_m && !wr) |=> (q.cap == $past(q.cnt)))
		else $error("capture value wrong");

	// capture mode rolls over to zero, never reloads
	cap_noreload_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ovf && cap_m && !wr) |=> (q.cnt == 16'h0000))
		else $error("capture mode reloaded");

	// down count underflow loads all ones
	down_under_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ovf && down && !wr) |=> (q.cnt == 16'hFFFF))
		else $error("underflow did not load all ones");

	// up overflow in reload mode loads the capture value
	up_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ovf && rld_m && !down && !wr) |=> (q.cnt == $past(q.cap)))
		else $error("reload value wrong");

	// trigger ignored with the enable clear
	trig_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!q.ctrl[EXEN_BIT] && cap_m && !wr) |=> $stable(q.cap))
		else $error("capture without trigger enable");

	// checks below that a write could upset leave out software writes, since a counter or capture write wins over
	// the hardware update of the same cycle, and any write can change the watched state

	// receive pulse comes one clock after an overflow with select set
	rx_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		baud_tick.rx |-> ($past(ovf) && $past(q.ctrl[RCLK_BIT])))
		else $error("stray receive clock pulse");

	// every overflow with receive select set reaches the uart
	rx_route_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ovf && q.ctrl[RCLK_BIT]) |=> baud_tick.rx)
		else $error("receive clock pulse missing");

	// every overflow with transmit select set reaches the uart
	tx_route_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ovf && q.ctrl[TX_CLOCK_SELECT_BIT]) |=> baud_tick.tx)
		else $error("transmit clock pulse missing");

	// no external flag without the trigger enable outside up/down
	exf_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!q.ctrl[EXEN_BIT] && !updown_m && !q.ctrl[EXF_BIT] && !wr) |=> !q.ctrl[EXF_BIT])
		else $error("external flag without trigger enable");

	// baud duty: trigger edge never loads the counter
	baud_noreload_a: assert property (@(posedge pclk) disable iff (!presetn)
		(tedge && baud_m && !ev && !wr) |=> $stable(q.cnt))
		else $error("trigger reloaded in baud duty");

	// machine tick spacing is fixed by the free running prescaler
	tick_space_a: assert property (@(posedge pclk) disable iff (!presetn)
		mtick |=> (!mtick [*5] ##1 mtick))
		else $error("machine tick spacing wrong");

	// internal timer source holds between machine ticks
	int_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		(run && !q.ctrl[CT_BIT] && !baud_m && !clkout_m && !mtick && !wr) |=> $stable(q.cnt))
		else $error("timer counted between machine ticks");

	// up count steps by exactly one
	up_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ev && !down && !hit && !tedge && !wr) |=> (q.cnt == $past(q.cnt) + 16'h0001))
		else $error("up count step wrong");

	// down count steps by exactly one
	down_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ev && down && !hit && !wr) |=> (q.cnt == $past(q.cnt) - 16'h0001))
		else $error("down count step wrong");

	// a stopped unit raises no flag and captures nothing
	off_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!run && !wr) |=> ($stable(q.ctrl) && $stable(q.cap)))
		else $error("stopped unit changed state");

	// pin level only toggles in clock-out duty
	clkout_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!clkout_m |=> $stable(q.clk_o))
		else $error("clock-out level moved outside clock-out");

	// up/down rollover flips the external flag
	exf_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ovf && updown_m && !wr) |=> (q.ctrl[EXF_BIT] != $past(q.ctrl[EXF_BIT])))
		else $error("external flag did not toggle");

	// hardware raises the external flag only on a machine tick
	exf_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
		($rose(q.ctrl[EXF_BIT]) && !$past(wr)) |-> $past(mtick))
		else $error("external flag set off a machine tick");

	// overflow flag is cleared by software only
	flag_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		(q.ctrl[TF_BIT] && !wr) |=> q.ctrl[TF_BIT])
		else $error("overflow flag cleared by hardware");

	// external flag is cleared by software or the up/down toggle only
	ext_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		(q.ctrl[EXF_BIT] && !wr && !(ovf && updown_m)) |=> q.ctrl[EXF_BIT])
		else $error("external flag cleared by hardware");

	// mode select bits of the control register follow software alone
	ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && idx == CTRL_IDX) |=> (q.ctrl[5:0] == $past(pwdata[5:0])))
		else $error("control write lost");

	// mode register write lands
	mode_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && idx == MODE_IDX) |=> (q.mode == $past(pwdata[1:0])))
		else $error("mode write lost");

	// capture registers move only on a trigger edge in capture mode
	cap_only_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cap_m && !tedge && !wr) |=> $stable(q.cap))
		else $error("capture value moved without edge");
endmodule
`default_nettype wire

// ---- testbench/tt3_pins.sv ----
// far-side pin model: count pin pulses and trigger input level
`timescale 1ns/100ps
`default_nettype none
module tt3_pins (
	// clock
	input wire logic pclk,
	// requests from the bench
	input wire logic cnt_go,
	input wire logic trg_go,
	input wire logic trg_lo,
	input wire logic [4:0] hold,
	// pin levels
	output logic cpin,
	output logic trig
);
	int cn = 0;
	int tn = 0;
	// low phase spans two machine cycles or more, so edges stay slow
	always @(posedge pclk)
	begin
		cn <= cnt_go ? 12 + int'(hold) : (cn > 0 ? cn - 1 : 0);
		tn <= trg_go ? 12 + int'(hold) : (tn > 0 ? tn - 1 : 0);
	end
	// idle level high, the pins are pulled up
	assign cpin = (cn == 0);
	assign trig = !(trg_lo || tn > 0);
endmodule
`default_nettype wire

// ---- testbench/tt3_timer_test.sv ----
// self-checking bench of the third timer/counter unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module tt3_timer_test;
	import tt3_pkg::*;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0, penable = 0, pwrite = 0, cnt_go = 0, trg_go = 0, trg_lo = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready, pslverr, cpin_o, cpin_oe_n, cpin_m, trig, irq, e;
	logic [4:0] hold = '0;
	logic [7:0] q;
	logic [15:0] r, c;
	tt3_baud_t baud_tick;
	int err_count = 0, comparisons = 0, rx_n = 0, tx_n = 0, rx0, tx0, n;
	wire logic pin = cpin_oe_n ? cpin_m : cpin_o;
	tt3_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_pin_i(pin),
		.count_pin_o(cpin_o), .count_pin_oe_n(cpin_oe_n), .trigger_input_i(trig), .baud_tick(baud_tick), .irq(irq));
	tt3_pins far (.pclk(pclk), .cnt_go(cnt_go), .trg_go(trg_go), .trg_lo(trg_lo), .hold(hold), .cpin(cpin_m),
		.trig(trig));
	// clock
	initial
	begin
		forever #20 pclk = ~pclk;
	end
	// uart pulse tallies
	always @(posedge pclk)
	begin
		rx_n <= rx_n + int'(baud_tick.rx);
		tx_n <= tx_n + int'(baud_tick.tx);
	end
	// one apb transfer; no wait count assumed
	task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata[7:0];
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rd(input logic [9:0] i, input logic [7:0] x);
		apb(0, i, 8'h00);
		`CHK(q, x)
	endtask
	task automatic wr16(input logic [9:0] i, input logic [15:0] v);
		apb(1, i, v[7:0]);
		apb(1, i + 10'h001, v[15:8]);
	endtask
	task automatic rd16(input logic [9:0] i, input logic [15:0] x);
		rd(i, x[7:0]);
		rd(i + 10'h001, x[15:8]);
	endtask
	// k falling pulses on the count pin (t=0) or the trigger (t=1)
	task automatic pulse(input int k, input bit t);
		repeat (k)
		begin
			@(posedge pclk);
			hold <= 5'($urandom % 8);
			cnt_go <= !t;
			trg_go <= t;
			@(posedge pclk);
			cnt_go <= 0;
			trg_go <= 0;
			repeat (44) @(posedge pclk);
		end
	endtask
	// counter after k up events, reloading rl on overflow
	function automatic logic [15:0] adv(input logic [15:0] v, input int k, input logic [15:0] rl);
		repeat (k) v = (v == 16'hFFFF) ? rl : v + 16'h0001;
		return v;
	endfunction
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// watchdog, far beyond the fewer than two thousand cycles the tests need
	initial
	begin
		repeat (30000) @(posedge pclk);
		err_count++;
		end_sim();
	end
	// main sequence
	initial
	begin
		void'($urandom(91));
		repeat (16) @(posedge pclk);
		presetn <= 1;
		rd(CTRL_IDX, 8'h00);
		rd(MODE_IDX, 8'h00);
		`CHK(irq, 1'b0)
		apb(0, 10'h0D0, 8'h00);
		`CHK(e, 1'b1)
		$display("test reset done");
		r = {1'b0, 15'($urandom)};
		n = 1 + $urandom % 3;
		apb(1, CTRL_IDX, 8'h0B);
		wr16(CNTL_IDX, r);
		apb(1, CTRL_IDX, 8'h0F);
		pulse(n, 0);
		pulse(1, 1);
		rd(CTRL_IDX, 8'h4F);
		apb(1, CTRL_IDX, 8'h0B);
		c = adv(r, n, 16'h0000);
		rd16(CAPL_IDX, c);
		pulse(2, 0);
		rd16(CNTL_IDX, c);
		$display("test capture done");
		n = $urandom % 3;
		apb(1, IEN_IDX, 8'h01);
		wr16(CNTL_IDX, 16'hFFFF - 16'(n));
		apb(1, CTRL_IDX, 8'h07);
		pulse(1, 1);
		pulse(n + 1, 0);
		rd(CTRL_IDX, 8'h87);
		`CHK(irq, 1'b1)
		apb(1, CTRL_IDX, 8'h03);
		@(negedge pclk);
		`CHK(irq, 1'b0)
		rd16(CNTL_IDX, 16'h0000);
		rd16(CAPL_IDX, c);
		$display("test overflow done");
		c = {1'b0, 15'($urandom)};
		wr16(CAPL_IDX, c);
		wr16(CNTL_IDX, 16'hFFFF);
		apb(1, CTRL_IDX, 8'h0E);
		pulse(3, 0);
		rd(CTRL_IDX, 8'h8E);
		pulse(1, 1);
		rd(CTRL_IDX, 8'hCE);
		apb(1, CTRL_IDX, 8'h0A);
		rd16(CNTL_IDX, c);
		$display("test reload done");
		for (int s = 1; s < 4; s++)
		begin
			apb(1, CTRL_IDX, 8'h00);
			wr16(CNTL_IDX, 16'hFFFF);
			rx0 = rx_n;
			tx0 = tx_n;
			apb(1, CTRL_IDX, {2'b00, 2'(s), 4'hF});
			pulse(2, 0);
			`CHK(rx_n - rx0, int'(s[1]))
			`CHK(tx_n - tx0, int'(s[0]))
			pulse(1, 1);
			rd(CTRL_IDX, {2'b01, 2'(s), 4'hF});
			apb(1, CTRL_IDX, 8'h0B);
			rd16(CNTL_IDX, adv(16'hFFFF, 2, c));
		end
		$display("test baud done");
		apb(1, CTRL_IDX, 8'h00);
		apb(1, MODE_IDX, 8'h01);
		wr16(CNTL_IDX, c + 16'h0002);
		trg_lo <= 1;
		apb(1, CTRL_IDX, 8'h06);
		pulse(3, 0);
		rd(CTRL_IDX, 8'hC6);
		trg_lo <= 0;
		pulse(1, 0);
		rd(CTRL_IDX, 8'h86);
		apb(1, CTRL_IDX, 8'h02);
		rd16(CNTL_IDX, c);
		$display("test updown done");
		apb(1, MODE_IDX, 8'h02);
		wr16(CNTL_IDX, 16'hFFF0);
		apb(1, CTRL_IDX, 8'h04);
		repeat (40) @(posedge pclk);
		`CHK(cpin_oe_n, 1'b0)
		`CHK(cpin_o, 1'b1)
		rd(CTRL_IDX, 8'h04);
		apb(1, MODE_IDX, 8'h00);
		@(negedge pclk);
		`CHK(cpin_oe_n, 1'b1)
		$display("test clockout done");
		apb(1, CTRL_IDX, 8'h00);
		wr16(CNTL_IDX, 16'h1000);
		apb(1, CTRL_IDX, 8'h04);
		// the stopping write adds three edges, so ten machine ticks in all
		repeat (10 * MACH_DIV - 3) @(posedge pclk);
		apb(1, CTRL_IDX, 8'h00);
		rd16(CNTL_IDX, 16'h100A);
		$display("test tick done");
		end_sim();
	end
endmodule
`default_nettype wire
